// ===== rtl/bst_pkg.sv
package bst_pkg;

  // ---------------------------------------------------------------
  // register map (printed offsets are not word aligned: index * 4)
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_SQL_ASSERT  = 16'h1AA8;
  localparam logic [15:0] IDX_SQL_HOLD    = 16'h1AA9;
  localparam logic [15:0] IDX_TX_BITCNT   = 16'h1AB0;
  localparam logic [15:0] IDX_TRANS_WIN   = 16'h1AB1;
  localparam logic [15:0] IDX_STATUS      = 16'h1AB2;
  localparam logic [15:0] IDX_RX_MAXTIME  = 16'h1AB3;
  localparam logic [17:0] ADDR_SQL_ASSERT = {IDX_SQL_ASSERT, 2'b00};
  localparam logic [17:0] ADDR_SQL_HOLD   = {IDX_SQL_HOLD, 2'b00};
  localparam logic [17:0] ADDR_TX_BITCNT  = {IDX_TX_BITCNT, 2'b00};
  localparam logic [17:0] ADDR_TRANS_WIN  = {IDX_TRANS_WIN, 2'b00};
  localparam logic [17:0] ADDR_STATUS     = {IDX_STATUS, 2'b00};
  localparam logic [17:0] ADDR_RX_MAXTIME = {IDX_RX_MAXTIME, 2'b00};

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_TIMING   = 8'h00;
  localparam int         STAT_SQL_BIT  = 0;
  localparam int         STAT_ACT_BIT  = 1;
  localparam int         STAT_TXB_BIT  = 2;
  localparam int         MAXT_HI_LSB   = 0;
  localparam int         MAXT_LO_LSB   = 8;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int WIN_SCALE   = 4;
  localparam int WIN_EXTRA   = 1;
  localparam int CLK_MHZ     = 40;

  typedef struct packed {
    logic [17:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bst_req_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_BUSY = 3'b010,
    TX_LAST = 3'b100
  } bst_tx_e;

endpackage : bst_pkg

// ===== rtl/bst_bmc_timing.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
// Functional notes
// RL1: squelch asserts on three edges within window
// RL2: assert window equals value times four plus one
// RL3: software sizes window to three half-bits
// RL4: window ignores duty-cycle distortion
// RL5: recommended assert value is 70
// RL6: squelch held for hold interval after activity
// RL7: hold interval equals value times four plus one
// RL8: hold about one half-bit; recommended 23
// RL9: squelch drop uses max high/low pulse times
// RL10: encoder times final bit with bit-period count
// RL11: bit count is clock kHz over kbps minus one
// RL12: bit count may be changed for testing
// RL13: recommended bit-period value is 159
// RL14: activity on three transitions in one window
// RL15: idle after full window without three transitions
// RL16: transition window is value times four exactly
// RL17: transition window kept between 12 and 20 us
// RL18: recommended transition window value is 200
// RL19: four 8-bit RW timing registers reset zero
// RL20: windows slide from oldest of last three edges
module bst_bmc_timing #(
  parameter int CNT_W = 11
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [17:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // receive line
  input  wire logic        rxLine,
  output logic             squelchActive,
  output logic             lineActive,
  // transmit encoder handshake
  input  wire logic        txLastBitStart,
  output logic             txLastBitDone
);

  // window counts reach 255 * 4 + 1; the check rejects counters narrower than 11 bits
  if (CNT_W < 11) begin : gCntWCheck
    $error("CNT_W too small for 255*4+1");
  end

  // ---------------------------------------------------------------
  // line synchroniser
  // ---------------------------------------------------------------
  // a level counts once stages two and three agree; short glitches are lost
  logic [2:0] syncQ, syncD;
  logic       lineQ, lineD;
  logic       edgeSeen;

  always_comb begin
    syncD = {syncQ[1:0], rxLine};
    lineD = (syncQ[1] == syncQ[2]) ? syncQ[2] : lineQ;
    edgeSeen = (syncQ[1] == syncQ[2]) && (syncQ[2] != lineQ);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  sqlAssert_q, sqlAssert_d;
  logic [7:0]  sqlHold_q, sqlHold_d;
  logic [7:0]  txBitCnt_q, txBitCnt_d;
  logic [7:0]  transWin_q, transWin_d;
  logic [15:0] rxMaxTime_q, rxMaxTime_d;
  logic [31:0] rdata_q, rdata_d;

  function automatic logic hit(input logic [17:0] a, input logic [17:0] b);
    hit = (a == b);
  endfunction : hit

  always_comb begin
    sqlAssert_d = sqlAssert_q;
    sqlHold_d   = sqlHold_q;
    txBitCnt_d  = txBitCnt_q;
    transWin_d  = transWin_q;
    rxMaxTime_d = rxMaxTime_q;
    rdata_d     = 32'h0000_0000;
    // unmapped writes change nothing; unmapped reads return zero
    if (regWr) begin
      unique case (1'b1)
        hit(regAddr, bst_pkg::ADDR_SQL_ASSERT): sqlAssert_d = regWdata[7:0]; // [RL19]
        hit(regAddr, bst_pkg::ADDR_SQL_HOLD):   sqlHold_d   = regWdata[7:0]; // [RL19]
        hit(regAddr, bst_pkg::ADDR_TX_BITCNT):  txBitCnt_d  = regWdata[7:0]; // [RL19]
        hit(regAddr, bst_pkg::ADDR_TRANS_WIN):  transWin_d  = regWdata[7:0]; // [RL19]
        hit(regAddr, bst_pkg::ADDR_RX_MAXTIME): rxMaxTime_d = regWdata[15:0];
        default:                                rxMaxTime_d = rxMaxTime_q;
      endcase
    end
    if (regRd) begin
      unique case (1'b1)
        hit(regAddr, bst_pkg::ADDR_SQL_ASSERT): rdata_d = {24'h000000, sqlAssert_q};
        hit(regAddr, bst_pkg::ADDR_SQL_HOLD):   rdata_d = {24'h000000, sqlHold_q};
        hit(regAddr, bst_pkg::ADDR_TX_BITCNT):  rdata_d = {24'h000000, txBitCnt_q};
        hit(regAddr, bst_pkg::ADDR_TRANS_WIN):  rdata_d = {24'h000000, transWin_q};
        hit(regAddr, bst_pkg::ADDR_RX_MAXTIME): rdata_d = {16'h0000, rxMaxTime_q};
        hit(regAddr, bst_pkg::ADDR_STATUS): begin
          rdata_d[bst_pkg::STAT_SQL_BIT] = squelchActive;
          rdata_d[bst_pkg::STAT_ACT_BIT] = lineActive;
          rdata_d[bst_pkg::STAT_TXB_BIT] = txLastBitDone;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // edge history
  // ---------------------------------------------------------------
  // age of the two previous edges; third is the current one
  logic [CNT_W-1:0] age1_q,        age1_d;
  logic [CNT_W-1:0] age2_q,        age2_d;
  logic [1:0]       nEdge_q,       nEdge_d;
  logic [CNT_W-1:0] sinceEdge_q,   sinceEdge_d;

  // ages stop at all ones, so a long quiet line never wraps to a fresh edge
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  always_comb begin
    age1_d      = sat_inc(age1_q);
    age2_d      = sat_inc(age2_q);
    nEdge_d     = nEdge_q;
    sinceEdge_d = sat_inc(sinceEdge_q);
    if (edgeSeen) begin
      age1_d      = '0;
      age2_d      = sat_inc(age1_q);                                // [RL20]
      sinceEdge_d = '0;
      if (nEdge_q != 2'd2) nEdge_d = nEdge_q + 2'd1;
    end
  end

  // ---------------------------------------------------------------
  // squelch and activity decisions
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] assertWin;
  logic [CNT_W-1:0] holdWin;
  logic [CNT_W-1:0] transWinCyc;
  logic [CNT_W-1:0] maxHi;
  logic [CNT_W-1:0] maxLo;
  logic             threeInAssert;
  logic             threeInTrans;
  logic             sql_q,         sql_d;
  logic             act_q,         act_d;
  logic             holdPending_q, holdPending_d;
  logic [CNT_W-1:0] holdCnt_q,     holdCnt_d;

  always_comb begin
    assertWin   = CNT_W'(sqlAssert_q) * CNT_W'(bst_pkg::WIN_SCALE)
                + CNT_W'(bst_pkg::WIN_EXTRA);                       // [RL2]
    holdWin     = CNT_W'(sqlHold_q) * CNT_W'(bst_pkg::WIN_SCALE)
                + CNT_W'(bst_pkg::WIN_EXTRA);                       // [RL7]
    transWinCyc = CNT_W'(transWin_q) * CNT_W'(bst_pkg::WIN_SCALE); // [RL16]
    maxHi = CNT_W'(rxMaxTime_q[bst_pkg::MAXT_HI_LSB +: 8]);
    maxLo = CNT_W'(rxMaxTime_q[bst_pkg::MAXT_LO_LSB +: 8]);
    // age2 is the oldest of the last three edges when a new edge lands
    threeInAssert = edgeSeen && (nEdge_q == 2'd2) && (age2_q < assertWin);   // [RL1] [RL20]
    threeInTrans  = edgeSeen && (nEdge_q == 2'd2) && (age2_q < transWinCyc); // [RL14] [RL20]
    act_d = act_q;
    if (threeInTrans) act_d = 1'b1;                                 // [RL14]
    else if (age2_q >= transWinCyc) act_d = 1'b0;                  // [RL15]
    sql_d = sql_q;
    holdPending_d = holdPending_q;
    holdCnt_d = holdCnt_q;
    // hold only starts once the line sits still past its max pulse time
    if (threeInAssert) begin
      sql_d = 1'b1;                                                 // [RL1]
      holdPending_d = 1'b0;
    end else if (sql_q && !holdPending_q && !edgeSeen
                 && sinceEdge_q > (lineQ ? maxHi : maxLo)) begin
      holdPending_d = 1'b1;                                         // [RL9]
      holdCnt_d = '0;
    end else if (holdPending_q) begin
      if (edgeSeen) holdPending_d = 1'b0;
      else if (holdCnt_q + 1'b1 >= holdWin) begin
        sql_d = 1'b0;                                               // [RL6]
        holdPending_d = 1'b0;
      end else holdCnt_d = holdCnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // transmit last-bit timer
  // ---------------------------------------------------------------
  bst_pkg::bst_tx_e txSt_q, txSt_d;
  logic [7:0]       txCnt_q, txCnt_d;
  logic             txDone_d;

  always_comb begin
    txSt_d = txSt_q;
    txCnt_d = txCnt_q;
    txDone_d = 1'b0;
    // starts while busy are ignored; the encoder waits for done
    unique case (txSt_q)
      bst_pkg::TX_IDLE: begin
        if (txLastBitStart) begin
          txCnt_d = txBitCnt_q;                                     // [RL10]
          txSt_d = bst_pkg::TX_BUSY;
        end
      end
      bst_pkg::TX_BUSY: begin
        if (txCnt_q == 8'h00) txSt_d = bst_pkg::TX_LAST;
        else txCnt_d = txCnt_q - 8'h01;                             // [RL10]
      end
      bst_pkg::TX_LAST: begin
        txDone_d = 1'b1;
        txSt_d = bst_pkg::TX_IDLE;
      end
      default: txSt_d = bst_pkg::TX_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // synchroniser registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      syncQ         <= 3'h0;
      lineQ         <= 1'b0;
    end else begin
      syncQ         <= syncD;
      lineQ         <= lineD;
    end
  end

  // ---------------------------------------------------------------
  // timing registers and read data
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sqlAssert_q   <= bst_pkg::RST_TIMING;                        // [RL19]
      sqlHold_q     <= bst_pkg::RST_TIMING;
      txBitCnt_q    <= bst_pkg::RST_TIMING;
      transWin_q    <= bst_pkg::RST_TIMING;
      rxMaxTime_q   <= 16'h0000;
      regRdata      <= 32'h0000_0000;
    end else begin
      sqlAssert_q   <= sqlAssert_d;
      sqlHold_q     <= sqlHold_d;
      txBitCnt_q    <= txBitCnt_d;
      transWin_q    <= transWin_d;
      rxMaxTime_q   <= rxMaxTime_d;
      regRdata      <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // edge history registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      age1_q        <= '1;
      age2_q        <= '1;
      nEdge_q       <= 2'd0;
      sinceEdge_q   <= '1;
    end else begin
      age1_q        <= age1_d;
      age2_q        <= age2_d;
      nEdge_q       <= nEdge_d;
      sinceEdge_q   <= sinceEdge_d;
    end
  end

  // ---------------------------------------------------------------
  // decision registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sql_q         <= 1'b0;
      act_q         <= 1'b0;
      holdPending_q <= 1'b0;
      holdCnt_q     <= '0;
      squelchActive <= 1'b0;
      lineActive    <= 1'b0;
    end else begin
      sql_q         <= sql_d;
      act_q         <= act_d;
      holdPending_q <= holdPending_d;
      holdCnt_q     <= holdCnt_d;
      squelchActive <= sql_d;
      lineActive    <= act_d;
    end
  end

  // ---------------------------------------------------------------
  // transmit registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      txSt_q        <= bst_pkg::TX_IDLE;
      txCnt_q       <= 8'h00;
      txLastBitDone <= 1'b0;
    end else begin
      txSt_q        <= txSt_d;
      txCnt_q       <= txCnt_d;
      txLastBitDone <= txDone_d;
    end
  end

endmodule : bst_bmc_timing

// ===== bench/bst_bmc_timing_sva.sv
`timescale 1ns/1ps
module bst_bmc_timing_sva #(
  parameter int CNT_W = 11
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // register port
  input wire logic [17:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  // line and encoder
  input wire logic        rxLine,
  input wire logic        squelchActive,
  input wire logic        lineActive,
  input wire logic        txLastBitStart,
  input wire logic        txLastBitDone
);
  // --------------------------------
  // shadows and ages
  // --------------------------------
  // ages run from the raw line, so sync delay is inside the margins
  logic [7:0]       txCnt_q, win_q, hold_q;
  logic [CNT_W-1:0] edgeAge_q, txAge_q;
  logic             lastLine_q;
  always_ff @(posedge ref_clk) begin
    lastLine_q <= rxLine;
    if (!rst_b) begin
      {txCnt_q, win_q, hold_q} <= 24'h0;
      edgeAge_q <= '1;
      txAge_q <= '1;
    end else begin
      if (regWr && regAddr == bst_pkg::ADDR_TX_BITCNT) txCnt_q <= regWdata[7:0];
      if (regWr && regAddr == bst_pkg::ADDR_TRANS_WIN) win_q <= regWdata[7:0];
      if (regWr && regAddr == bst_pkg::ADDR_SQL_HOLD) hold_q <= regWdata[7:0];
      edgeAge_q <= (rxLine != lastLine_q) ? '0 : edgeAge_q + CNT_W'(edgeAge_q != '1);
      txAge_q <= txLastBitStart ? CNT_W'(1) : txAge_q + CNT_W'(txAge_q != '1);
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence rdCnt;
    regRd && regAddr == bst_pkg::ADDR_TX_BITCNT;
  endsequence
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data not zero when idle");
  rd_value_a: assert property (rdCnt |=> regRdata == {24'h0, txCnt_q})
    else $error("bit count readback wrong");
  done_pulse_a: assert property (txLastBitDone |=> !txLastBitDone)
    else $error("done longer than one cycle");
  done_time_a: assert property (txLastBitDone |-> txAge_q == CNT_W'(txCnt_q) + CNT_W'(3))
    else $error("final bit time wrong");
  sql_rise_a: assert property ($rose(squelchActive) |-> edgeAge_q <= 8)
    else $error("squelch rose without edge");
  act_rise_a: assert property ($rose(lineActive) |-> edgeAge_q <= 8)
    else $error("activity rose without edge");
  sql_fall_a: assert property ($fell(squelchActive) |-> edgeAge_q > {hold_q, 2'b00})
    else $error("squelch dropped before hold");
  idle_bound_a: assert property (edgeAge_q > {win_q, 2'b00} + 8 |-> !lineActive)
    else $error("line not idle after window");
endmodule : bst_bmc_timing_sva

bind bst_bmc_timing bst_bmc_timing_sva #(.CNT_W(CNT_W)) u_sva (
  .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxLine(rxLine),
  .squelchActive(squelchActive), .lineActive(lineActive),
  .txLastBitStart(txLastBitStart), .txLastBitDone(txLastBitDone)
);

// ===== bench/bst_far_port.sv
`timescale 1ns/1ps
module bst_far_port (
  // clock
  input wire logic ref_clk,
  // line toward the block
  output logic     line
);
  // line rests at its last level between bursts, like a real port
  initial line = 1'b0;
  task automatic burst(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge ref_clk);
      line <= ~line;
    end
  endtask : burst
endmodule : bst_far_port

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk, rst_b, regWr, regRd, rxLine, txLastBitStart;
  logic        squelchActive, lineActive, txLastBitDone;
  logic [17:0] regAddr;
  logic [31:0] regWdata, regRdata;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [17:0] addrs [4] = '{bst_pkg::ADDR_SQL_ASSERT, bst_pkg::ADDR_SQL_HOLD,
                             bst_pkg::ADDR_TX_BITCNT, bst_pkg::ADDR_TRANS_WIN};
  logic [31:0] vals [4] = '{32'h46, 32'h17, 32'h9F, 32'hC8};
  logic [7:0]  txCnts [3] = '{8'h00, 8'h0A, 8'h9F};
  bst_bmc_timing #(.CNT_W(11)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .rxLine(rxLine), .squelchActive(squelchActive), .lineActive(lineActive),
    .txLastBitStart(txLastBitStart), .txLastBitDone(txLastBitDone));
  bst_far_port farPort (.ref_clk(ref_clk), .line(rxLine));
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [17:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(what, exp, regRdata);
  endtask : rd
  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : waitc
  // edge count from start taken to done seen
  task automatic txrun(input logic [7:0] cnt);
    int k;
    wr(bst_pkg::ADDR_TX_BITCNT, {24'h0, cnt});
    @(posedge ref_clk);
    txLastBitStart <= 1'b1;
    @(posedge ref_clk);
    txLastBitStart <= 1'b0;
    k = 1;
    #1;
    while (txLastBitDone !== 1'b1 && k < 400) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk("tx done delay", 32'(cnt) + 32'h3, k);
  endtask : txrun
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // --------------------------------
  // clock, watchdog, tests
  // --------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #250000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {regAddr, regWdata, regWr, regRd, txLastBitStart, rst_b} = '0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) rd(addrs[i], 32'h0, "reset value");
    for (int i = 0; i < 4; i++) wr(addrs[i], vals[i]);
    for (int i = 0; i < 4; i++) rd(addrs[i], vals[i], "readback");
    wr(18'h00000, 32'hFF);
    rd(18'h00000, 32'h0, "unmapped");
    wr(bst_pkg::ADDR_RX_MAXTIME, 32'h0A0A);
    rd(bst_pkg::ADDR_RX_MAXTIME, 32'h0A0A, "max time");
    farPort.burst(3, 10);
    waitc(8);
    chk("squelch on", 1'b1, squelchActive);
    chk("active on", 1'b1, lineActive);
    rd(bst_pkg::ADDR_STATUS, 32'h3, "status");
    waitc(32);
    chk("squelch hold", 1'b1, squelchActive);
    waitc(110);
    chk("squelch drop", 1'b0, squelchActive);
    waitc(610);
    chk("active late", 1'b1, lineActive);
    waitc(45);
    chk("idle", 1'b0, lineActive);
    farPort.burst(3, 150);
    waitc(8);
    chk("squelch wide", 1'b0, squelchActive);
    chk("active wide", 1'b1, lineActive);
    for (int i = 0; i < 3; i++) txrun(txCnts[i]);
    final_report();
  end
endmodule : tb_top
